// File: hdl/cis_pkg.sv
// Package: shared constants and types for the configuration init sequencer
package cis_pkg;
    // Clock rate and derived cycle counts
    localparam int CLK_MHZ       = 200;
    localparam int CLK_START_NS  = 20;   // Settle time after ungated clocks start
    localparam int REG_INIT_NS   = 40;   // User register initialisation time
    localparam int ROW_STEP_NS   = 15;   // Base spacing between row releases
    localparam int CLK_START_CYC = (CLK_START_NS * CLK_MHZ + 999) / 1000;
    localparam int REG_INIT_CYC  = (REG_INIT_NS * CLK_MHZ + 999) / 1000;
    localparam int ROW_STEP_CYC  = (ROW_STEP_NS * CLK_MHZ + 999) / 1000;
    // Fabric geometry
    localparam int NUM_SECTORS   = 4;
    localparam int NUM_ROWS      = 4;
    // Register byte offsets
    localparam logic [11:0] CTRL_OFS   = 12'h000;
    localparam logic [11:0] STATUS_OFS = 12'h004;
    localparam logic [11:0] ERR_OFS    = 12'h008;
    // Control register fields
    localparam int CTRL_INIT_OFF_BIT = 0;
    localparam int CTRL_RU_GO_BIT    = 1;
    localparam int CTRL_IMG_LSB      = 4;
    localparam int IMG_W             = 4;
    localparam logic [31:0] CTRL_RST = 32'h0000_0010;
    // Error register fields
    localparam int ERR_STICKY_BIT    = 0;
    localparam int ERR_IMG_LSB       = 4;
    localparam int ERR_CNT_LSB       = 8;
    localparam logic [IMG_W-1:0] FACTORY_IMG = 4'h0;
    // Sequencer states, Gray along idle..user
    typedef enum logic [2:0] {
        CIS_IDLE  = 3'b000,
        CIS_LOAD  = 3'b001,
        CIS_CLKS  = 3'b011,
        CIS_INIT  = 3'b010,
        CIS_REL   = 3'b110,
        CIS_USER  = 3'b111,
        CIS_ERR   = 3'b100
    } cis_state_e;
endpackage

// File: hdl/cis_sector_if.sv
// Interface: link between the sequencer and one sector manager
`timescale 1ns/1ps
interface cis_sector_if;
    logic                start;
    logic [cis_pkg::NUM_ROWS-1:0] row_frozen;
    logic                user_mode;
    modport seq  (output start, input row_frozen, input user_mode);
    modport sect (input start, output row_frozen, output user_mode);
endinterface

// File: hdl/cis_sector_mgr.sv
// Module: one sector manager, releases its rows one after another
`timescale 1ns/1ps
module cis_sector_mgr
    import cis_pkg::*;
#(
    parameter int IDX = 0
) (
    input  wire logic   pclk,
    input  wire logic   presetn,
    cis_sector_if.sect  sif
);
    // Own step spacing per sector, so sectors drift apart with no common timing
    localparam logic [7:0] STEP = 8'(ROW_STEP_CYC + IDX);

    logic [NUM_ROWS-1:0] frz_reg, frz_next;
    logic [7:0]          cnt_reg, cnt_next;

    // Next row release: lowest frozen row thaws when the step count expires
    always_comb begin
        frz_next = frz_reg;
        cnt_next = cnt_reg;
        if (!sif.start) begin
            frz_next = '1;
            cnt_next = STEP;
        end else if (frz_reg != '0) begin
            if (cnt_reg == 8'h01) begin
                frz_next = frz_reg & (frz_reg - 1'b1);
                cnt_next = STEP;
            end else begin
                cnt_next = cnt_reg - 8'h01;
            end
        end
    end

    // State registers; each manager runs from its own start only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frz_reg <= '1;
            cnt_reg <= 8'h01;
        end else begin
            frz_reg <= frz_next;
            cnt_reg <= cnt_next;
        end
    end

    // Rows read as frozen the moment start drops, not one edge later
    assign sif.row_frozen = sif.start ? frz_reg : '1;
    assign sif.user_mode  = sif.start && (frz_reg == '0);

    // At most one row thaws per edge
    a_row_one_step: assert property (@(posedge pclk) disable iff (!presetn)
        sif.start && $past(sif.start) |-> $countones($past(frz_reg) ^ frz_reg) <= 1)
        else $error("more than one row released at once");
endmodule

// File: hdl/cis_top.sv
// Module: configuration init sequencer top with APB registers and sector managers
//
// Functional notes
// - One sector manager per sector, releasing only its own rows.
// - Global freeze holds all fabric registers while configuration runs.
// - Rows inside a sector thaw one after another.
// - Sector managers run concurrently, with no synchronisation between them.
// - Fabric-live asserts only after every sector reports user mode.
// - Request high leaves idle, drives status high and starts loading.
// - Load-complete asserts after full data received, before clocks start.
// - Ungated clocks start after load-complete, then user registers initialise.
// - Pipeline registers shift once clocks run; init only if not disabled.
// - User register initialisation finishes before fabric-live asserts.
// - Fabric-live and internal release output assert together at the end.
// - Frozen registers ignore clock edges; released ones update normally.
// - Embedded memory contents stay untouched during configuration.
// - Option bit suppresses power-up register initialisation.
// - Remote-update command starts reconfiguration from the selected image.
// - Errors are checked during loading and in the post-load check.
// - Application image errors fall back to factory image with error status.
// - Internal release output is the inverse of fabric-live.
// - Request low after reset drives the status line low.
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module cis_top
    import cis_pkg::*;
(
    input  wire logic                pclk,
    input  wire logic                presetn,
    // APB slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic [31:0]              prdata,
    output logic                     pready,
    output logic                     pslverr,
    // Host pins
    input  wire logic                cfg_request_n,
    output logic                     cfg_status_n,
    output logic                     load_complete,
    output logic                     fabric_live,
    output logic                     fabric_live_n,
    // Image loader
    output logic                     img_load_req,
    output logic [IMG_W-1:0]         img_sel,
    input  wire logic                img_done,
    input  wire logic                img_err,
    input  wire logic                check_err,
    // Fabric controls
    output logic                     global_freeze,
    output logic                     clocks_run,
    output logic                     reg_init_en,
    output logic                     pipe_init_en,
    output logic                     mem_wr_block,
    output logic [NUM_SECTORS*NUM_ROWS-1:0] row_frozen
);
    cis_state_e          st_reg, st_next;
    logic [2:0]          rq_sync_reg;
    logic                rq_reg, rq_next;
    logic [7:0]          tmr_reg, tmr_next;
    logic [IMG_W-1:0]    img_reg, img_next;
    logic                lc_reg, lc_next;
    logic                live_reg, live_next;
    logic                stat_reg, stat_next;
    logic                fb_reg, fb_next;
    logic [31:0]         ctrl_reg, ctrl_next;
    logic [31:0]         err_reg, err_next;
    logic [NUM_SECTORS-1:0] sec_user;
    logic                all_user;
    logic                wr_acc, rd_acc, ru_go;
    logic                load_fail, err_event;

    // Request pin synchroniser; only agreeing later stages update the level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rq_sync_reg <= 3'b000;
        end else begin
            rq_sync_reg <= {rq_sync_reg[1:0], cfg_request_n};
        end
    end
    assign rq_next = (rq_sync_reg[1] == rq_sync_reg[2]) ? rq_sync_reg[2] : rq_reg;

    // Sector managers, each on its own interface
    cis_sector_if sif [NUM_SECTORS] ();
    for (genvar s = 0; s < NUM_SECTORS; s++) begin : g_sec
        assign sif[s].start = (st_reg == CIS_REL) || (st_reg == CIS_USER);
        assign sec_user[s]  = sif[s].user_mode;
        assign row_frozen[s*NUM_ROWS +: NUM_ROWS] = sif[s].row_frozen;
        cis_sector_mgr #(.IDX(s)) u_sec (
            .pclk    (pclk),
            .presetn (presetn),
            .sif     (sif[s])
        );
    end
    assign all_user = &sec_user;

    // APB decode; zero-wait slave
    assign wr_acc  = psel && penable && pwrite;
    assign rd_acc  = psel && penable && !pwrite;
    assign pready  = 1'b1;
    assign ru_go   = wr_acc && (paddr == CTRL_OFS) && pwdata[CTRL_RU_GO_BIT];
    assign load_fail = (st_reg == CIS_LOAD) && img_err;
    assign err_event = load_fail || ((st_reg == CIS_INIT) && check_err);

    // Unmapped addresses answer with an error
    always_comb begin
        pslverr = 1'b0;
        if (psel && penable) begin
            pslverr = !(paddr == CTRL_OFS || paddr == STATUS_OFS || paddr == ERR_OFS);
        end
    end

    // Main sequence next state
    always_comb begin
        st_next   = st_reg;
        tmr_next  = tmr_reg;
        img_next  = img_reg;
        lc_next   = lc_reg;
        live_next = live_reg;
        stat_next = stat_reg;
        fb_next   = fb_reg;
        if (!rq_reg) begin
            st_next   = CIS_IDLE;
            stat_next = 1'b0;
            lc_next   = 1'b0;
            live_next = 1'b0;
            fb_next   = 1'b0;
        end else begin
            case (st_reg)
                CIS_IDLE: begin
                    st_next   = CIS_LOAD;
                    stat_next = 1'b1;
                    img_next  = ctrl_reg[CTRL_IMG_LSB +: IMG_W];
                end
                CIS_LOAD: begin
                    if (img_err) begin
                        if (img_reg != FACTORY_IMG) begin
                            img_next = FACTORY_IMG;
                            fb_next  = 1'b1;
                        end else begin
                            st_next   = CIS_ERR;
                            stat_next = 1'b0;
                        end
                    end else if (img_done) begin
                        lc_next  = 1'b1;
                        st_next  = CIS_CLKS;
                        tmr_next = 8'(CLK_START_CYC);
                    end
                end
                CIS_CLKS: begin
                    if (tmr_reg == 8'h01) begin
                        st_next  = CIS_INIT;
                        tmr_next = 8'(REG_INIT_CYC);
                    end else begin
                        tmr_next = tmr_reg - 8'h01;
                    end
                end
                CIS_INIT: begin
                    if (check_err) begin
                        lc_next = 1'b0;
                        if (img_reg != FACTORY_IMG) begin
                            img_next = FACTORY_IMG;
                            fb_next  = 1'b1;
                            st_next  = CIS_LOAD;
                        end else begin
                            st_next   = CIS_ERR;
                            stat_next = 1'b0;
                        end
                    end else if (tmr_reg == 8'h01) begin
                        st_next = CIS_REL;
                    end else begin
                        tmr_next = tmr_reg - 8'h01;
                    end
                end
                CIS_REL: begin
                    if (all_user) begin
                        st_next   = CIS_USER;
                        live_next = 1'b1;
                    end
                end
                CIS_USER: begin
                    if (ru_go) begin
                        st_next   = CIS_LOAD;
                        img_next  = pwdata[CTRL_IMG_LSB +: IMG_W];
                        lc_next   = 1'b0;
                        live_next = 1'b0;
                        fb_next   = 1'b0;
                    end
                end
                CIS_ERR: begin
                    stat_next = 1'b0;
                end
                default: begin
                    st_next = CIS_IDLE;
                end
            endcase
        end
    end

    // Registers: control, error status (set wins over write-one clear)
    always_comb begin
        ctrl_next = ctrl_reg;
        err_next  = err_reg;
        if (wr_acc && paddr == CTRL_OFS) begin
            ctrl_next = pwdata & 32'h0000_00F1;  // Go bit self-clears
        end
        if (wr_acc && paddr == ERR_OFS && pwdata[ERR_STICKY_BIT]) begin
            err_next[ERR_STICKY_BIT] = 1'b0;
        end
        if (err_event) begin
            err_next[ERR_STICKY_BIT]            = 1'b1;
            err_next[ERR_IMG_LSB +: IMG_W]      = img_reg;
            err_next[ERR_CNT_LSB +: 8]          = err_reg[ERR_CNT_LSB +: 8] + 8'h01;
        end
    end

    // All sequencer state registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rq_reg   <= 1'b0;
            st_reg   <= CIS_IDLE;
            tmr_reg  <= 8'h01;
            img_reg  <= FACTORY_IMG;
            lc_reg   <= 1'b0;
            live_reg <= 1'b0;
            stat_reg <= 1'b0;
            fb_reg   <= 1'b0;
            ctrl_reg <= CTRL_RST;
            err_reg  <= 32'h0000_0000;
        end else begin
            rq_reg   <= rq_next;
            st_reg   <= st_next;
            tmr_reg  <= tmr_next;
            img_reg  <= img_next;
            lc_reg   <= lc_next;
            live_reg <= live_next;
            stat_reg <= stat_next;
            fb_reg   <= fb_next;
            ctrl_reg <= ctrl_next;
            err_reg  <= err_next;
        end
    end

    // Read data, registered at the end of the setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                CTRL_OFS:   prdata <= ctrl_reg;
                STATUS_OFS: prdata <= {20'h00000, img_reg, 1'b0, fb_reg,
                                       live_reg, lc_reg, 1'b0, st_reg};
                ERR_OFS:    prdata <= err_reg;
                default:    prdata <= 32'h0000_0000;
            endcase
        end
    end

    // Pin and fabric outputs, all from state flops
    assign cfg_status_n  = stat_reg;
    assign load_complete = lc_reg;
    assign fabric_live   = live_reg;
    assign fabric_live_n = !live_reg;
    assign img_load_req  = (st_reg == CIS_LOAD);
    assign img_sel       = img_reg;
    assign global_freeze = !((st_reg == CIS_REL) || (st_reg == CIS_USER));
    // Clocks hold off one cycle so load-complete is seen strictly first
    assign clocks_run    = lc_reg && (st_reg != CIS_LOAD) &&
                           !((st_reg == CIS_CLKS) && (tmr_reg == 8'(CLK_START_CYC)));
    assign reg_init_en   = (st_reg == CIS_INIT) && !ctrl_reg[CTRL_INIT_OFF_BIT];
    assign pipe_init_en  = clocks_run && !ctrl_reg[CTRL_INIT_OFF_BIT];
    assign mem_wr_block  = !live_reg;

    // Checks on the sequence
    sequence s_done_then_clk;
        $rose(load_complete) ##1 (st_reg == CIS_CLKS);
    endsequence
    a_live_needs_all: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(fabric_live) |-> $past(all_user))
        else $error("fabric live before all sectors in user mode");
    a_live_inverse: assert property (@(posedge pclk) disable iff (!presetn)
        fabric_live_n == !fabric_live)
        else $error("release output not inverse of fabric live");
    a_req_low_status: assert property (@(posedge pclk) disable iff (!presetn)
        !rq_reg |=> !cfg_status_n && !fabric_live && !load_complete)
        else $error("status not low after request low");
    a_idle_to_load: assert property (@(posedge pclk) disable iff (!presetn)
        (st_reg == CIS_IDLE) && rq_reg |=> cfg_status_n && img_load_req)
        else $error("request high did not start loading");
    a_done_before_clk: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(clocks_run) |-> load_complete && $past(load_complete))
        else $error("clocks started before load complete");
    a_clk_seq_order: assert property (@(posedge pclk) disable iff (!presetn)
        s_done_then_clk |-> !reg_init_en)
        else $error("register init overlaps clock start");
    a_freeze_held: assert property (@(posedge pclk) disable iff (!presetn)
        (st_reg inside {CIS_LOAD, CIS_CLKS, CIS_INIT}) |-> global_freeze && &row_frozen)
        else $error("fabric not frozen during configuration");
    a_init_before_live: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(fabric_live) |-> $past(st_reg, 1) == CIS_REL && !reg_init_en)
        else $error("fabric live without finished init");
    a_fallback_factory: assert property (@(posedge pclk) disable iff (!presetn)
        load_fail && rq_reg && img_reg != FACTORY_IMG |=> img_sel == FACTORY_IMG
        && err_reg[ERR_STICKY_BIT])
        else $error("no fallback to factory image");
    a_ru_restart: assert property (@(posedge pclk) disable iff (!presetn)
        (st_reg == CIS_USER) && ru_go && rq_reg |=> img_load_req && !fabric_live)
        else $error("remote update did not restart");
    a_init_off: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_reg[CTRL_INIT_OFF_BIT] |-> !reg_init_en && !pipe_init_en)
        else $error("init active while suppressed");
endmodule

// File: verif/cis_host_model.sv
// Partner model: image loader that answers load requests and can fail one image
`timescale 1ns/1ps
module cis_host_model
    import cis_pkg::*;
#(
    parameter int LOAD_CYC = 6
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             img_load_req,
    input  wire logic [IMG_W-1:0] img_sel,
    input  wire logic             bad_en,
    input  wire logic [IMG_W-1:0] bad_img,
    output logic                  img_done,
    output logic                  img_err
);
    int cnt;
    // Each attempt ends in one pulse, so a retry after a failure starts a fresh count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt      <= 0;
            img_done <= 1'b0;
            img_err  <= 1'b0;
        end else begin
            img_done <= 1'b0;
            img_err  <= 1'b0;
            if (!img_load_req || img_done || img_err) begin
                cnt <= 0;
            end else if (cnt == LOAD_CYC) begin
                cnt <= 0;
                img_err  <= bad_en && (img_sel == bad_img);
                img_done <= !(bad_en && (img_sel == bad_img));
            end else begin
                cnt <= cnt + 1;
            end
        end
    end
endmodule

// File: verif/test_config_init_sequencer.sv
// Testbench: pin handshake, image loading, row release and registers of the sequencer
`timescale 1ns/1ps
module test_config_init_sequencer;
    import cis_pkg::*;
    logic                            pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0]                     paddr;
    logic [31:0]                     pwdata, prdata, rd;
    logic                            cfg_request_n, cfg_status_n, load_complete, err;
    logic                            fabric_live, fabric_live_n, img_load_req, img_done;
    logic                            img_err, bad_en, global_freeze, clocks_run, check_err;
    logic                            reg_init_en, pipe_init_en, mem_wr_block;
    logic [IMG_W-1:0]                img_sel, bad_img;
    logic [NUM_SECTORS*NUM_ROWS-1:0] row_frozen, rows_prev;
    int                              fails, samples_checked, n;
    cis_top u_cis_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cfg_request_n(cfg_request_n), .cfg_status_n(cfg_status_n),
        .load_complete(load_complete), .fabric_live(fabric_live),
        .fabric_live_n(fabric_live_n), .img_load_req(img_load_req), .img_sel(img_sel),
        .img_done(img_done), .img_err(img_err), .check_err(check_err),
        .global_freeze(global_freeze), .clocks_run(clocks_run), .reg_init_en(reg_init_en),
        .pipe_init_en(pipe_init_en), .mem_wr_block(mem_wr_block), .row_frozen(row_frozen)
    );
    cis_host_model u_cis_host_model (
        .pclk(pclk), .presetn(presetn), .img_load_req(img_load_req), .img_sel(img_sel),
        .bad_en(bad_en), .bad_img(bad_img), .img_done(img_done), .img_err(img_err)
    );
    // 200 MHz clock
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic endtest(input string name);
        $display("Test %s finished, mismatches so far %0d", name, fails);
    endtask
    // One APB transfer; the request holds until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // One idle edge, so a following call never re-raises psel in this time step
        @(posedge pclk);
    endtask
    // Bounded wait; the count of edges is handed back for timing checks
    task automatic wait_for(ref logic s, input logic v, output int cyc);
        cyc = 0;
        do begin
            @(posedge pclk);
            cyc++;
        end while (s !== v && cyc < 400);
        if (s !== v) chk(s, v);
    endtask
    task automatic tally_and_finish;
        $display("Counts: %0d compared, %0d mismatched", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Watch on every edge: thaw pace, live versus rows, inverse copies, freeze
    always @(posedge pclk) begin
        rows_prev <= row_frozen;
        if (presetn === 1'b1) begin
            for (int s = 0; s < NUM_SECTORS; s++) begin
                chk($countones(rows_prev[4*s+:4] & ~row_frozen[4*s+:4]) <= 1, 1'b1);
            end
            chk(fabric_live_n, !fabric_live);
            chk(mem_wr_block, !fabric_live);
            if (fabric_live === 1'b1) chk(row_frozen, '0);
            if (load_complete !== 1'b1) chk(global_freeze, 1'b1);
        end
    end
    // Watchdog sized well above the longest expected run
    initial begin
        #(6000 * 5);
        fails++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        tally_and_finish();
    end
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0;
        pwdata = '0; cfg_request_n = 1'b0; bad_en = 1'b0; bad_img = '0; check_err = 1'b0;
        fails = 0; samples_checked = 0;
        repeat (10) @(posedge pclk);
        chk({cfg_status_n, load_complete, fabric_live, fabric_live_n}, 4'b0001);
        chk(row_frozen, 16'hFFFF);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, CTRL_OFS, '0, rd, err);
        chk(rd, CTRL_RST);
        apb(1'b0, 12'hFFC, '0, rd, err);
        chk(err, 1'b1);
        chk(rd, 32'h0000_0000);
        endtest("reset");
        cfg_request_n <= 1'b1;
        wait_for(cfg_status_n, 1'b1, n);
        chk({load_complete, clocks_run, img_load_req, img_sel}, 7'h11);
        wait_for(load_complete, 1'b1, n);
        chk({clocks_run, reg_init_en, global_freeze}, 3'b001);
        wait_for(reg_init_en, 1'b1, n);
        chk(n, CLK_START_CYC);
        chk({global_freeze, pipe_init_en}, 2'b11);
        wait_for(global_freeze, 1'b0, n);
        chk(n, REG_INIT_CYC);
        chk(fabric_live, 1'b0);
        n = 0;
        while (row_frozen[3:0] !== 4'h0 && n < 200) begin
            @(posedge pclk);
            n++;
        end
        chk(row_frozen[15:12] != 4'h0, 1'b1);
        wait_for(fabric_live, 1'b1, n);
        chk({fabric_live_n, load_complete, cfg_status_n}, 3'b011);
        apb(1'b0, STATUS_OFS, '0, rd, err);
        chk(rd & 32'h0000_0F30, 32'h0000_0130);
        endtest("boot");
        bad_en  <= 1'b1;
        bad_img <= 4'h2;
        apb(1'b1, CTRL_OFS, 32'h0000_0022, rd, err);
        wait_for(load_complete, 1'b0, n);
        wait_for(img_err, 1'b1, n);
        chk({fabric_live, img_sel}, 5'h02);
        wait_for(fabric_live, 1'b1, n);
        chk(img_sel, FACTORY_IMG);
        apb(1'b0, ERR_OFS, '0, rd, err);
        chk(rd & 32'h0000_00F1, 32'h0000_0021);
        apb(1'b0, STATUS_OFS, '0, rd, err);
        chk(rd & 32'h0000_0F40, 32'h0000_0040);
        apb(1'b1, ERR_OFS, 32'h0000_0001, rd, err);
        apb(1'b0, ERR_OFS, '0, rd, err);
        chk(rd[0], 1'b0);
        endtest("fallback");
        cfg_request_n <= 1'b0;
        wait_for(cfg_status_n, 1'b0, n);
        chk({load_complete, fabric_live, global_freeze}, 3'b001);
        endtest("release");
        apb(1'b1, CTRL_OFS, 32'h0000_0031, rd, err);
        apb(1'b1, 12'h00C, 32'hFFFF_FFFF, rd, err);
        chk(err, 1'b1);
        cfg_request_n <= 1'b1;
        n = 0;
        rd = '0;
        while (fabric_live !== 1'b1 && n < 400) begin
            @(posedge pclk);
            n++;
            rd[0] = rd[0] | reg_init_en | pipe_init_en;
        end
        chk({rd[0], fabric_live, img_sel}, 6'h13);
        apb(1'b0, CTRL_OFS, '0, rd, err);
        chk(rd, 32'h0000_0031);
        endtest("no_init");
        // Post-load check fails on the application image and then on the factory image
        cfg_request_n <= 1'b0;
        wait_for(cfg_status_n, 1'b0, n);
        check_err     <= 1'b1;
        cfg_request_n <= 1'b1;
        wait_for(cfg_status_n, 1'b1, n);
        wait_for(cfg_status_n, 1'b0, n);
        chk(img_sel, FACTORY_IMG);
        chk({load_complete, fabric_live}, 2'b00);
        apb(1'b0, ERR_OFS, '0, rd, err);
        chk(rd & 32'h0000_FFF1, 32'h0000_0301);
        apb(1'b0, STATUS_OFS, '0, rd, err);
        chk(rd & 32'h0000_0047, 32'h0000_0044);
        endtest("post_check");
        tally_and_finish();
    end
endmodule
